// ===== verif/xid_decoder_props.sv
// Checker for xid_decoder: operation timing and address relations.
// Assumes a bind onto xid_decoder, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module xid_decoder_props
	import xid_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Issue side
	input wire logic op_valid_in,
	input wire logic [15:0] opcode_in,
	input wire logic [31:0] areg_in,
	input wire logic [3:0] chan_in,
	// Answers
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic mem_req_out,
	input wire logic dev_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic [31:0] chan_addr_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	wire logic acc;
	assign acc = op_valid_in && !busy_out;
	property p_range; acc && (opcode_in == OP_CIR || opcode_in == OP_CIRU)
		|=> !done_out ##[1:3] done_out; endproperty
	a_range: assert property (p_range) else $error("range check timing");
	property p_xs; acc && opcode_in == OP_XSWORD |=> !done_out ##1 done_out; endproperty
	a_xs: assert property (p_xs) else $error("sixteen extend timing");
	property p_xb; acc && opcode_in == OP_XBWORD |=> !done_out [*2] ##1 done_out; endproperty
	a_xb: assert property (p_xb) else $error("byte extend timing");
	property p_ldx; acc && (opcode_in == OP_LBX || opcode_in == OP_LSX)
		|=> done_out && mem_req_out && mem_addr_out == $past(areg_in); endproperty
	a_ldx: assert property (p_ldx) else $error("extending load");
	property p_dev; acc && opcode_in >= OP_DEV_FIRST && opcode_in <= OP_DEV_LAST
		|=> !done_out [*2] ##1 done_out; endproperty
	a_dev: assert property (p_dev) else $error("device op timing");
	property p_devsp; mem_req_out && dev_out
		|-> mem_addr_out >= 32'h20000000 && mem_addr_out <= 32'h3FFFFFFF; endproperty
	a_devsp: assert property (p_devsp) else $error("device outside peripherals");
	property p_trap; acc && (opcode_in == OP_LDTRAPPED || opcode_in == OP_STTRAPPED)
		|=> !done_out [*8] ##1 !done_out [*2] ##1 done_out; endproperty
	a_trap: assert property (p_trap) else $error("trapped transfer timing");
	property p_chan; chan_addr_out == 32'h80000000 + {26'h0, chan_in, 2'h0}; endproperty
	a_chan: assert property (p_chan) else $error("channel word address");
endmodule
`default_nettype wire

// ===== verif/xid_decoder_tb.sv
// Self-checking bench for xid_decoder, one task per scenario.
// Assumes a stand-alone run; the checker is bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module xid_decoder_tb
	import xid_pkg::*;
();
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic op_valid_in = 1'b0;
	logic queue_empty_in = 1'b1;
	logic trap_pri_in = 1'b0;
	logic boot_from_rom_in = 1'b0;
	logic [15:0] opcode_in = 16'h0000;
	logic [31:0] areg_in = 32'h0, breg_in = 32'h0, creg_in = 32'h0, mem_rdata_in = 32'h0;
	logic [1:0] trap_group_in = 2'h0;
	logic [3:0] link_boot_in = 4'h0;
	logic [3:0] chan_in = 4'h0;
	logic busy_out, done_out, range_error_out, mem_req_out, dev_out, access_fault_out;
	logic illegal_out, mem_write_out, queue_front_out;
	logic seen_wr = 1'b0, seen_ill = 1'b0, seen_front = 1'b0, clr_seen = 1'b0;
	logic boot_wait_out;
	logic [31:0] result_out, mem_addr_out, chan_addr_out, boot_pc_out, req_addr;
	logic [1:0] boot_link_out;
	logic seen_req = 1'b0, seen_dev = 1'b0, seen_fault = 1'b0;
	int fails = 0;
	int tests_run = 0;
	int cyc;
	always #12.5 clk_in = ~clk_in;
	xid_decoder i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .op_valid_in(op_valid_in),
		.opcode_in(opcode_in), .busy_out(busy_out), .done_out(done_out),
		.illegal_out(illegal_out),
		.areg_in(areg_in), .breg_in(breg_in), .creg_in(creg_in), .result_out(result_out),
		.range_error_out(range_error_out), .mem_req_out(mem_req_out),
		.mem_write_out(mem_write_out),
		.dev_out(dev_out), .mem_addr_out(mem_addr_out), .mem_size_out(), .mem_wdata_out(),
		.mem_rdata_in(mem_rdata_in), .access_fault_out(access_fault_out),
		.queue_front_out(queue_front_out), .queue_empty_in(queue_empty_in),
		.trap_pri_in(trap_pri_in),
		.trap_group_in(trap_group_in), .boot_from_rom_in(boot_from_rom_in),
		.link_boot_in(link_boot_in), .boot_wait_out(boot_wait_out),
		.boot_link_out(boot_link_out), .boot_pc_out(boot_pc_out), .chan_in(chan_in),
		.chan_addr_out(chan_addr_out));
	// Latch the first request, since it stands for one cycle only, or for four cycles on trap transfers
	// Clear comes first so that an event in the same edge still lands
	always @(posedge clk_in) begin
		if (clr_seen) begin
			seen_req <= 1'b0;
			seen_dev <= 1'b0;
			seen_wr <= 1'b0;
			seen_fault <= 1'b0;
			seen_ill <= 1'b0;
			seen_front <= 1'b0;
		end
		if (mem_req_out === 1'b1 && (!seen_req || clr_seen)) begin
			seen_req <= 1'b1;
			req_addr <= mem_addr_out;
			seen_dev <= dev_out;
			seen_wr <= mem_write_out;
		end
		if (access_fault_out === 1'b1)
			seen_fault <= 1'b1;
		if (illegal_out === 1'b1)
			seen_ill <= 1'b1;
		if (queue_front_out === 1'b1)
			seen_front <= 1'b1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Issue while idle, count cycles to done, return once result has landed
	task automatic run_op(input logic [15:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] c);
		@(negedge clk_in);
		clr_seen = 1'b1;
		op_valid_in = 1'b1;
		opcode_in = op;
		areg_in = a;
		breg_in = b;
		creg_in = c;
		@(negedge clk_in);
		clr_seen = 1'b0;
		op_valid_in = 1'b0;
		cyc = 1;
		while (done_out !== 1'b1 && cyc < 20) begin
			@(negedge clk_in);
			cyc++;
		end
		@(negedge clk_in);
	endtask
	task automatic t_boot();
		repeat (3) @(negedge clk_in);
		chk(32'(boot_wait_out), 32'h1, "link wait");
		link_boot_in = 4'h6;
		for (int i = 0; i < 9; i++) begin
			chan_in = 4'(i);
			@(negedge clk_in);
		end
		chk(32'(busy_out), 32'h0, "boot left");
		chk(32'(boot_link_out), 32'h1, "boot link");
		chk(boot_pc_out, 32'h7FFFFFFE, "rom entry");
		nrst_in = 1'b0;
		boot_from_rom_in = 1'b1;
		link_boot_in = 4'h0;
		repeat (2) @(negedge clk_in);
		nrst_in = 1'b1;
		repeat (3) @(negedge clk_in);
		chk(32'(busy_out), 32'h0, "rom boot");
		chk(32'(boot_wait_out), 32'h0, "rom no wait");
		$display("t_boot done");
	endtask
	task automatic t_ext();
		run_op(OP_XSWORD, 32'h12348001, 32'h0, 32'h0);
		chk(32'(cyc), 32'h2, "xs cycles");
		chk(result_out, 32'hFFFF8001, "xs value");
		run_op(OP_XBWORD, 32'h55AA0080, 32'h0, 32'h0);
		chk(32'(cyc), 32'h3, "xb cycles");
		chk(result_out, 32'hFFFFFF80, "xb value");
		$display("t_ext done");
	endtask
	task automatic t_load();
		mem_rdata_in = 32'h80000000;
		run_op(OP_LBX, 32'h80000143, 32'h0, 32'h0);
		chk(32'(cyc), 32'h1, "lbx cycles");
		chk(result_out, 32'hFFFFFF80, "lbx lane");
		chk(req_addr, 32'h80000143, "lbx addr");
		mem_rdata_in = 32'h7FFF0000;
		run_op(OP_LSX, 32'h80000402, 32'h0, 32'h0);
		chk(32'(cyc), 32'h1, "lsx cycles");
		chk(result_out, 32'h00007FFF, "lsx lane");
		chk(32'(seen_fault), 32'h0, "user load");
		run_op(OP_LSX, 32'h8000013E, 32'h0, 32'h0);
		@(negedge clk_in);
		chk(32'(seen_fault), 32'h1, "private load");
		$display("t_load done");
	endtask
	task automatic t_range();
		run_op(OP_CIR, 32'h5, 32'h5, 32'h5);
		chk(32'(cyc), 32'h4, "cir in");
		chk(32'(range_error_out), 32'h0, "cir in err");
		run_op(OP_CIR, 32'hA, 32'h1, 32'h5);
		chk(32'(cyc), 32'h2, "cir low");
		chk(32'(range_error_out), 32'h1, "cir low err");
		run_op(OP_CIRU, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1);
		chk(32'(cyc), 32'h4, "ciru in");
		chk(32'(range_error_out), 32'h0, "ciru err");
		$display("t_range done");
	endtask
	task automatic t_dev();
		mem_rdata_in = 32'h81234567;
		for (int i = 0; i < 6; i++) begin
			run_op(OP_DEV_FIRST + 16'(i), 32'h20001000, 32'h5A, 32'h0);
			chk(32'(cyc), 32'h3, "dev cycles");
			chk(32'(seen_dev), 32'h1, "dev hit");
			chk(32'(seen_wr), 32'(i & 1), "dev direction");
			if (i == 0)
				chk(result_out, 32'h00000067, "devlb value");
			if (i == 4)
				chk(result_out, 32'h81234567, "devlw value");
		end
		run_op(OP_DEV_LAST, 32'h80000400, 32'h0, 32'h0);
		chk(32'(seen_dev), 32'h0, "dev to memory");
		queue_empty_in = 1'b1;
		run_op(OP_INSQ, 32'h80001000, 32'h0, 32'h0);
		chk(32'(cyc), 32'h1, "insq short");
		chk(32'(seen_front), 32'h1, "insq front");
		queue_empty_in = 1'b0;
		run_op(OP_INSQ, 32'h80001000, 32'h0, 32'h0);
		chk(32'(cyc), 32'h2, "insq long");
		run_op(16'h63F0, 32'h0, 32'h0, 32'h0);
		chk(32'(seen_ill), 32'h1, "unknown refused");
		chk(32'(busy_out), 32'h0, "unknown stays idle");
		$display("t_dev done");
	endtask
	task automatic t_trap();
		trap_pri_in = 1'b1;
		trap_group_in = 2'h3;
		run_op(OP_LDTRAPPED, 32'h0, 32'h0, 32'h0);
		chk(32'(cyc), 32'hB, "ld cycles");
		chk(req_addr, 32'h80000130, "ld struct");
		trap_pri_in = 1'b0;
		trap_group_in = 2'h1;
		run_op(OP_STTRAPPED, 32'h0, 32'h0, 32'h0);
		chk(32'(cyc), 32'hB, "st cycles");
		chk(req_addr, 32'h80000070, "st struct");
		$display("t_trap done");
	endtask
	task automatic results();
		$display("Counts: %0d compared, %0d failed", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk_in);
		nrst_in = 1'b1;
		t_boot();
		t_ext();
		t_load();
		t_range();
		t_dev();
		t_trap();
		results();
	end
	// Some twenty-seven times the expected run
	initial begin
		repeat (4000) @(posedge clk_in);
		fails++;
		results();
	end
endmodule
bind xid_decoder xid_decoder_props i_props (.clk_in(clk_in), .nrst_in(nrst_in),
	.op_valid_in(op_valid_in), .opcode_in(opcode_in), .areg_in(areg_in), .chan_in(chan_in),
	.busy_out(busy_out), .done_out(done_out), .mem_req_out(mem_req_out), .dev_out(dev_out),
	.mem_addr_out(mem_addr_out), .chan_addr_out(chan_addr_out));
`default_nettype wire

// ===== verilog/xid_addr_map.sv
// Combinational address map: word/byte split, bank, region classification.
// Assumes addresses are 32-bit signed, as seen by the processor.
`timescale 1ns/10ps
`default_nettype none
module xid_addr_map
	import xid_pkg::*;
(
	// Address
	input wire logic [31:0] addr_in,
	// Decoded
	output logic [29:0] word_addr_out,
	output logic [1:0] byte_sel_out,
	output logic [1:0] bank_out,
	output logic in_ram_out,
	output logic private_out,
	output logic periph_out
);
	// Unsigned offset from the bottom of memory
	wire [31:0] rel = addr_in - LOWEST_SIGNED_ADDRESS;
	assign word_addr_out = addr_in[31:2];
	assign byte_sel_out = addr_in[1:0];
	assign bank_out = addr_in[BANK_MSB:BANK_MSB-1];
	assign in_ram_out = rel < RAM_BYTES;
	assign private_out = rel < (USER_BOUNDARY_ADDRESS - LOWEST_SIGNED_ADDRESS);
	assign periph_out = (addr_in >= PERIPH_BASE) && (addr_in <= PERIPH_TOP);
endmodule
`default_nettype wire

// ===== verilog/xid_decoder.sv
// Extended instruction decoder and sequencer with system address helpers.
// Assumes opcodes arrive from the fetch unit in clk_in domain, operands
// from the evaluation stack, and one-word memory answers in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module xid_decoder
	import xid_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Instruction issue
	input wire logic op_valid_in,
	input wire logic [15:0] opcode_in,
	output logic busy_out,
	output logic done_out,
	output logic illegal_out,
	// Evaluation stack operands
	input wire logic [31:0] areg_in,
	input wire logic [31:0] breg_in,
	input wire logic [31:0] creg_in,
	output logic [31:0] result_out,
	output logic range_error_out,
	// Memory / device port
	output logic mem_req_out,
	output logic mem_write_out,
	output logic dev_out,
	output logic [31:0] mem_addr_out,
	output logic [1:0] mem_size_out,
	output logic [31:0] mem_wdata_out,
	input wire logic [31:0] mem_rdata_in,
	output logic access_fault_out,
	// Scheduler
	output logic queue_front_out,
	input wire logic queue_empty_in,
	// Trap area
	input wire logic trap_pri_in,
	input wire logic [1:0] trap_group_in,
	// Boot
	input wire logic boot_from_rom_in,
	input wire logic [NUM_LINK_IN-1:0] link_boot_in,
	output logic boot_wait_out,
	output logic [1:0] boot_link_out,
	output logic [31:0] boot_pc_out,
	// Channel state word address
	input wire logic [3:0] chan_in,
	output logic [31:0] chan_addr_out
);
	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_EXEC} xid_state_t;
	xid_state_t state;
	xid_op_t op;
	logic [3:0] cnt;
	logic [3:0] last;
	logic [31:0] a, b, c;
	logic [31:0] result;
	logic rerr;
	logic [1:0] boot_link;
	logic [NUM_LINK_IN-1:0] link_s1, link_s2;
	logic [31:0] next_result;
	logic next_rerr;

	// Opcode decode
	wire is_dev = (opcode_in >= OP_DEV_FIRST) && (opcode_in <= OP_DEV_LAST);
	wire xid_op_t dec_op =
		(opcode_in == OP_CIR) ? XID_CIR :
		(opcode_in == OP_CIRU) ? XID_CIRU :
		(opcode_in == OP_XSWORD) ? XID_XSWORD :
		(opcode_in == OP_XBWORD) ? XID_XBWORD :
		(opcode_in == OP_LBX) ? XID_LBX :
		(opcode_in == OP_LSX) ? XID_LSX :
		(is_dev && !opcode_in[0]) ? XID_DEVLD :
		(is_dev && opcode_in[0]) ? XID_DEVST :
		(opcode_in == OP_INSQ) ? XID_INSQ :
		(opcode_in == OP_LDTRAPPED) ? XID_LDTRAPPED :
		(opcode_in == OP_STTRAPPED) ? XID_STTRAPPED : XID_NONE;
	// Device size: 0 byte, 1 sixteen, 2 word
	wire [1:0] dev_size = opcode_in[2:1];

	// Range check: short path when below lower bound
	wire s_lo_fail = $signed(b) < $signed(c);
	wire s_hi_fail = $signed(b) > $signed(a);
	wire u_lo_fail = b < c;
	wire u_hi_fail = b > a;
	wire [3:0] range_last = (op == XID_CIR ? s_lo_fail : u_lo_fail) ?
		CYC_RANGE_MIN : CYC_RANGE_MAX;

	// Trapped-process structure address
	wire [31:0] trap_struct = TRAP_BASE
		+ {24'h000000, trap_pri_in, trap_group_in, 5'h00}
		+ STRUCT_BYTES;
	wire [3:0] trap_word = cnt - 4'h1;
	wire trap_xfer = (op == XID_LDTRAPPED || op == XID_STTRAPPED) && cnt >= 4'h1 && cnt <= 4'h4;

	// Address map helper for memory-side accesses
	wire [29:0] word_addr;
	wire [1:0] byte_sel;
	wire [1:0] bank;
	wire in_ram, priv, periph;
	xid_addr_map u_map (
		.addr_in(a),
		.word_addr_out(word_addr),
		.byte_sel_out(byte_sel),
		.bank_out(bank),
		.in_ram_out(in_ram),
		.private_out(priv),
		.periph_out(periph)
	);

	// Sign extension unit, fed by stack or memory data
	wire use_mem = (op == XID_LBX) || (op == XID_LSX) || (op == XID_DEVLD);
	wire [31:0] ext_src = use_mem ? mem_rdata_in : a;
	wire ext_half = (op == XID_XSWORD) || (op == XID_LSX) ||
		(op == XID_DEVLD && mem_size_out == 2'h1);
	wire [1:0] ext_sel = use_mem ? byte_sel : 2'h0;
	wire [31:0] ext_val;
	xid_extend u_ext (
		.data_in(ext_src),
		.byte_sel_in(ext_sel),
		.half_in(ext_half),
		.ext_out(ext_val)
	);

	wire finishing = (state == ST_EXEC) && (cnt == last);
	wire accept = (state == ST_IDLE) && op_valid_in;
	wire mem_op = (op == XID_LBX) || (op == XID_LSX) || (op == XID_DEVLD) || (op == XID_DEVST);
	// Standard loads into the private area are flagged; trap opcodes are exempt
	wire priv_hit = (op == XID_LBX || op == XID_LSX) && priv;
	wire link_any = |link_s2;

	always_comb begin
		next_result = result;
		next_rerr = rerr;
		if (finishing) begin
			unique case (op)
				XID_CIR: next_rerr = s_lo_fail | s_hi_fail;
				XID_CIRU: next_rerr = u_lo_fail | u_hi_fail;
				XID_XSWORD, XID_XBWORD: next_result = ext_val;
				XID_LBX, XID_LSX: next_result = ext_val;
				XID_DEVLD: next_result = (mem_size_out == 2'h2) ? mem_rdata_in : ext_val;
				XID_LDTRAPPED: next_result = trap_struct;
				default: next_result = result;
			endcase
		end
	end

	// Sequencer
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state <= ST_BOOT;
			op <= XID_NONE;
			cnt <= 4'h0;
			last <= 4'h0;
			a <= 32'h00000000;
			b <= 32'h00000000;
			c <= 32'h00000000;
			mem_size_out <= 2'h0;
		end else begin
			unique case (state)
				ST_BOOT: if (boot_from_rom_in || link_any) state <= ST_IDLE;
				ST_IDLE: if (op_valid_in) begin
					op <= dec_op;
					a <= areg_in;
					b <= breg_in;
					c <= creg_in;
					cnt <= 4'h1;
					mem_size_out <= is_dev ? dev_size :
						(opcode_in == OP_LSX ? 2'h1 : 2'h0);
					unique case (dec_op)
						XID_XSWORD: last <= CYC_XSWORD;
						XID_XBWORD: last <= CYC_XBWORD;
						XID_LBX, XID_LSX: last <= CYC_LOADX;
						XID_DEVLD, XID_DEVST: last <= CYC_DEV;
						XID_INSQ: last <= queue_empty_in ? CYC_INSQ_MIN : CYC_INSQ_MAX;
						XID_LDTRAPPED, XID_STTRAPPED: last <= CYC_TRAP;
						XID_CIR, XID_CIRU: last <= CYC_RANGE_MAX;
						default: last <= 4'h1;
					endcase
					if (dec_op != XID_NONE)
						state <= ST_EXEC;
				end
				ST_EXEC: begin
					cnt <= cnt + 4'h1;
					if ((op == XID_CIR || op == XID_CIRU) && cnt == 4'h1)
						last <= range_last;
					if (finishing)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			result <= 32'h00000000;
			rerr <= 1'b0;
			access_fault_out <= 1'b0;
		end else begin
			result <= next_result;
			rerr <= accept ? 1'b0 : next_rerr;
			access_fault_out <= finishing && priv_hit;
		end
	end

	// Link boot channel select
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			link_s1 <= '0;
			link_s2 <= '0;
			boot_link <= 2'h0;
		end else begin
			link_s1 <= link_boot_in;
			link_s2 <= link_s1;
			if (state == ST_BOOT && !boot_from_rom_in)
				for (int i = NUM_LINK_IN - 1; i >= 0; i--)
					if (link_s2[i])
						boot_link <= 2'(i);
		end
	end

	// Outputs
	assign busy_out = state != ST_IDLE;
	assign done_out = finishing;
	assign illegal_out = accept && (dec_op == XID_NONE);
	assign result_out = result;
	assign range_error_out = rerr;
	// Memory strobe lands on the final cycle for loads and device ops so data is captured then; trap transfers strobe on cycles 1 to 4
	assign mem_req_out = (finishing && mem_op) || trap_xfer;
	assign mem_write_out = (op == XID_DEVST && finishing) || (op == XID_STTRAPPED && trap_xfer);
	assign dev_out = (op == XID_DEVLD || op == XID_DEVST) && periph;
	assign mem_addr_out = trap_xfer ?
		trap_struct + {28'h0000000, trap_word[1:0], 2'h0} :
		{word_addr, byte_sel};
	assign mem_wdata_out = (op == XID_STTRAPPED) ? a : b;
	assign queue_front_out = (op == XID_INSQ) && finishing;
	assign boot_wait_out = (state == ST_BOOT) && !boot_from_rom_in;
	assign boot_link_out = boot_link;
	// Entry holds a short backward jump placed by the ROM image
	assign boot_pc_out = BOOT_ENTRY;
	assign chan_addr_out = LOWEST_SIGNED_ADDRESS + {26'h0000000, chan_in, 2'h0};
	wire unused = ^{bank, in_ram};
endmodule
`default_nettype wire

// ===== verilog/xid_extend.sv
// Sign extension of byte and sixteen-bit quantities, byte lane selected.
// Assumes little-endian byte numbering within a word.
`timescale 1ns/10ps
`default_nettype none
module xid_extend (
	// Operand
	input wire logic [31:0] data_in,
	input wire logic [1:0] byte_sel_in,
	input wire logic half_in,
	// Result
	output logic [31:0] ext_out
);
	wire [7:0] lane_b = data_in[{byte_sel_in, 3'b000} +: 8];
	wire [15:0] lane_h = byte_sel_in[1] ? data_in[31:16] : data_in[15:0];
	assign ext_out = half_in ? {{16{lane_h[15]}}, lane_h} : {{24{lane_b[7]}}, lane_b};
endmodule
`default_nettype wire

// ===== verilog/xid_pkg.sv
// Constants for the extended instruction decoder and system address map.
// Assumes a single 40 MHz processor clock and 32-bit signed addressing.
package xid_pkg;
	// Extended opcodes (prefixed memory codes)
	localparam logic [15:0] OP_CIR = 16'h2CF7;
	localparam logic [15:0] OP_CIRU = 16'h2CFC;
	localparam logic [15:0] OP_XSWORD = 16'h2FF8;
	localparam logic [15:0] OP_XBWORD = 16'h2BF8;
	localparam logic [15:0] OP_LBX = 16'h2BF9;
	localparam logic [15:0] OP_LSX = 16'h2FF9;
	localparam logic [15:0] OP_DEV_FIRST = 16'h2FF0;
	localparam logic [15:0] OP_DEV_LAST = 16'h2FF5;
	localparam logic [15:0] OP_INSQ = 16'h60F2;
	localparam logic [15:0] OP_LDTRAPPED = 16'h2CF6;
	localparam logic [15:0] OP_STTRAPPED = 16'h2CFB;
	// Cycle counts
	localparam logic [3:0] CYC_RANGE_MIN = 4'h2;
	localparam logic [3:0] CYC_RANGE_MAX = 4'h4;
	localparam logic [3:0] CYC_XSWORD = 4'h2;
	localparam logic [3:0] CYC_XBWORD = 4'h3;
	localparam logic [3:0] CYC_LOADX = 4'h1;
	localparam logic [3:0] CYC_DEV = 4'h3;
	localparam logic [3:0] CYC_INSQ_MIN = 4'h1;
	localparam logic [3:0] CYC_INSQ_MAX = 4'h2;
	localparam logic [3:0] CYC_TRAP = 4'hB;
	// Address map
	localparam logic [31:0] LOWEST_SIGNED_ADDRESS = 32'h80000000;
	localparam logic [31:0] HIGHEST_SIGNED_ADDRESS = 32'h7FFFFFFF;
	localparam logic [31:0] RAM_BYTES = 32'h00004000;
	localparam logic [31:0] TRAP_BASE = 32'h80000040;
	localparam logic [31:0] USER_BOUNDARY_ADDRESS = 32'h80000140;
	localparam logic [31:0] LINK_IN_BASE = 32'h80000010;
	localparam logic [31:0] BOOT_ENTRY = 32'h7FFFFFFE;
	localparam logic [31:0] PERIPH_BASE = 32'h20000000;
	localparam logic [31:0] PERIPH_TOP = 32'h3FFFFFFF;
	localparam int BANK_MSB = 31;
	localparam int NUM_LINK_IN = 4;
	localparam int NUM_CHAN = 9;
	localparam logic [31:0] STRUCT_BYTES = 32'h00000010;
	typedef enum logic [3:0] {
		XID_NONE, XID_CIR, XID_CIRU, XID_XSWORD, XID_XBWORD, XID_LBX, XID_LSX,
		XID_DEVLD, XID_DEVST, XID_INSQ, XID_LDTRAPPED, XID_STTRAPPED
	} xid_op_t;
endpackage
